// ===== logic/pfw_writer.sv
// Program flash block writer: holding registers, unlock, sequencer, APB slave
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pfw_defines.svh"

// Register map, byte offsets on the bus:
//   0x00 control  bit 0 start (cleared by hardware), bit 1 write enable,
//                 bit 2 program flash select, bit 3 error (write 1 clears)
//   0x04 unlock   0x55 then 0xAA arms one start; any other write disarms
//   0x08 pointer  table pointer, 16 bits
//   0x0C table    write loads the latch and one holding byte, pointer + 1
//   0x10 fence    pointers below it are write protected
//   0x14 status   bit 0 done, bit 1 error; sticky, write 1 to clear
//   0x18 mask     same layout as status
//   0x1C state    bit 0 core stalled, bit 1 unlock armed, bit 2 timer running
// Unmapped offsets read zero and answer with an error.

module pfw_writer #(
  parameter int unsigned PROG_CYCLES = `PFW_PROG_CYCLES
) (
  input  wire logic        CLK_SYS_I,   // System clock, 100 MHz
  input  wire logic        RST_I,       // Asynchronous reset, active high
  input  wire logic        PSEL_I,      // APB select
  input  wire logic        PENABLE_I,   // APB enable
  input  wire logic        PWRITE_I,    // APB direction, high for write
  input  wire logic [7:0]  PADDR_I,     // APB byte address
  input  wire logic [31:0] PWDATA_I,    // APB write data
  output logic      [31:0] PRDATA_O,    // APB read data
  output logic             PREADY_O,    // APB ready
  output logic             PSLVERR_O,   // APB error, unmapped address
  output logic             IRQ_O,       // Level interrupt
  output logic             CPU_STALL_O, // Suspends the core during a write
  output logic             FL_WE_O,     // Flash data load strobe
  output logic      [15:0] FL_ADDR_O,   // Flash byte address
  output logic      [7:0]  FL_DATA_O,   // Flash byte data
  output logic             FL_KEEP_O,   // Leave this flash byte untouched
  output logic             FL_PROG_O    // Flash programming pulse window
);

  // --------------------------------------------------------------------------
  // State and timer
  // --------------------------------------------------------------------------

  pfw_pkg::pfw_core_t c_q;
  pfw_pkg::pfw_core_t c_d;
  logic               tmr_busy;
  logic               tmr_done;

  // Write duration comes only from this counter; its busy flag is
  // shown in the state word so software can see the array at work
  pfw_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .CLK_SYS_I (CLK_SYS_I),
    .RST_I     (RST_I),
    .go_i      (c_q.tmr_go),
    .busy_o    (tmr_busy),
    .done_o    (tmr_done)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Known register offsets
  function automatic logic addr_hit(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `PFW_OFS_CTRL) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_UNLOCK) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_PTR) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_TBLWR) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_PROT) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_IRQSTS) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_IRQMSK) begin
      hit = 1'b1;
    end else if (a == `PFW_OFS_STAT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Sticky bits: hardware set beats a software clear in the same cycle
  function automatic logic [1:0] w1c(input logic [1:0] cur,
                                     input logic [1:0] clr,
                                     input logic [1:0] set);
    return (cur & ~clr) | set;
  endfunction

  // First byte address of the write block that holds a pointer
  function automatic logic [15:0] blk_base(input logic [15:0] p);
    return {p[15:`PFW_IDX_W], {`PFW_IDX_W{1'b0}}};
  endfunction

  // Protected below the fence, invalid at and above the top of the array
  function automatic logic ptr_bad(input logic [15:0] p,
                                   input logic [15:0] fence);
    logic bad;
    bad = 1'b0;
    if (p >= `PFW_FLASH_TOP) begin
      bad = 1'b1;
    end else if (p < fence) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------

  // Decode results of the current cycle
  logic       acc;
  logic       commit;
  logic       wr_go;
  logic [1:0] sts_set;
  logic [1:0] sts_clr;
  logic       err_set;
  logic       err_clr;
  logic       bad_ptr;

  // One always_comb holds the bus slave, unlock, sequencer and interrupts
  always_comb begin
    // Hold everything by default; strobes fall back to zero
    c_d        = c_q;
    c_d.tmr_go = 1'b0;
    c_d.fl_we  = 1'b0;
    acc        = PSEL_I && PENABLE_I;
    commit     = acc && c_q.pready;
    wr_go      = 1'b0;
    sts_set    = 2'b00;
    sts_clr    = 2'b00;
    err_set    = 1'b0;
    err_clr    = 1'b0;
    bad_ptr    = ptr_bad(c_q.ptr, c_q.prot);

    // ------------------------------------------------------------------------
    // Bus slave: answer and read data
    // ------------------------------------------------------------------------
    // APB: ready one cycle into the access phase, all outputs registered
    c_d.pready  = acc && !c_q.pready;
    c_d.pslverr = 1'b0;
    if (acc && !c_q.pready) begin
      c_d.pslverr = !addr_hit(PADDR_I);
      c_d.prdata  = 32'h0;
      if (!PWRITE_I) begin
        if (PADDR_I == `PFW_OFS_CTRL) begin
          c_d.prdata[`PFW_CTRL_WR]    = c_q.wr;
          c_d.prdata[`PFW_CTRL_WRITE_ENABLE_BIT]  = c_q.write_enable_bit;
          c_d.prdata[`PFW_CTRL_PMSEL] = c_q.pmsel;
          c_d.prdata[`PFW_CTRL_ERR]   = c_q.err;
        end else if (PADDR_I == `PFW_OFS_PTR) begin
          c_d.prdata[15:0] = c_q.ptr;
        end else if (PADDR_I == `PFW_OFS_TBLWR) begin
          c_d.prdata[7:0] = c_q.latch;
        end else if (PADDR_I == `PFW_OFS_PROT) begin
          c_d.prdata[15:0] = c_q.prot;
        end else if (PADDR_I == `PFW_OFS_IRQSTS) begin
          c_d.prdata[1:0] = c_q.sts;
        end else if (PADDR_I == `PFW_OFS_IRQMSK) begin
          c_d.prdata[1:0] = c_q.msk;
        end else if (PADDR_I == `PFW_OFS_STAT) begin
          c_d.prdata[0] = c_q.stall;
          c_d.prdata[1] = c_q.armed;
          c_d.prdata[2] = tmr_busy;
        end
      end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Register writes take effect on the edge that sees ready
    if (commit && PWRITE_I) begin
      if (PADDR_I == `PFW_OFS_UNLOCK) begin
        // Two keys in a row arm one start attempt
        if (PWDATA_I[7:0] == `PFW_KEY1) begin
          c_d.key1  = 1'b1;
          c_d.armed = 1'b0;
        end else if (PWDATA_I[7:0] == `PFW_KEY2 && c_q.key1) begin
          c_d.key1  = 1'b0;
          c_d.armed = 1'b1;
        end else begin
          c_d.key1  = 1'b0;
          c_d.armed = 1'b0;
        end
      end else begin
        // Any other write breaks the unlock sequence
        c_d.key1  = 1'b0;
        c_d.armed = 1'b0;
      end
      if (PADDR_I == `PFW_OFS_CTRL) begin
        c_d.write_enable_bit  = PWDATA_I[`PFW_CTRL_WRITE_ENABLE_BIT];
        c_d.pmsel = PWDATA_I[`PFW_CTRL_PMSEL];
        err_clr   = PWDATA_I[`PFW_CTRL_ERR];
        // Start needs unlock, write enable and program memory selected
        wr_go     = PWDATA_I[`PFW_CTRL_WR] && c_q.armed &&
                    PWDATA_I[`PFW_CTRL_WRITE_ENABLE_BIT] && PWDATA_I[`PFW_CTRL_PMSEL] &&
                    (c_q.state == pfw_pkg::PFW_IDLE);
      end else if (PADDR_I == `PFW_OFS_PTR) begin
        c_d.ptr = PWDATA_I[15:0];
      end else if (PADDR_I == `PFW_OFS_TBLWR) begin
        // Short write into the block buffer only; no protection check
        if (c_q.state == pfw_pkg::PFW_IDLE) begin
          c_d.latch              = PWDATA_I[7:0];
          c_d.hold[c_q.ptr[5:0]] = PWDATA_I[7:0];
          c_d.ptr                = c_q.ptr + 16'h1;
        end
      end else if (PADDR_I == `PFW_OFS_PROT) begin
        c_d.prot = PWDATA_I[15:0];
      end else if (PADDR_I == `PFW_OFS_IRQSTS) begin
        sts_clr = PWDATA_I[1:0];
      end else if (PADDR_I == `PFW_OFS_IRQMSK) begin
        c_d.msk = PWDATA_I[1:0];
      end
    end

    // Accepted start: suspend the core at once
    if (wr_go) begin
      c_d.wr    = 1'b1;
      c_d.stall = 1'b1;
      c_d.state = pfw_pkg::PFW_CHECK;
    end

    // ------------------------------------------------------------------------
    // Block programming sequencer
    // ------------------------------------------------------------------------
    // Timing after the edge E that accepts a start, with C the timer length:
    //   E+1           pointer check; a bad pointer ends the run here
    //   E+2..E+65     one holding byte per cycle towards the array
    //   E+65..E+66+C  programming window, opened with the last byte, while the timer runs
    //   E+68+C        done cycle: start bit and stall drop, done flag sets
    // The core stays stalled throughout, so table writes cannot race the
    // block load; the price is a core that sleeps for the whole write.
    // Stall therefore lasts C+68 cycles on a good run and one on a bad one.
    case (c_q.state)
      pfw_pkg::PFW_IDLE: begin
        // Nothing to do until a start is accepted
        c_d.fl_prog = 1'b0;
      end
      pfw_pkg::PFW_CHECK: begin
        if (bad_ptr) begin
          // Nothing reaches the flash; only the error is reported
          c_d.wr    = 1'b0;
          c_d.stall = 1'b0;
          err_set   = 1'b1;
          c_d.state = pfw_pkg::PFW_IDLE;
        end else begin
          // Whole block only: base is aligned to the block size
          c_d.base  = blk_base(c_q.ptr);
          c_d.idx   = '0;
          c_d.state = pfw_pkg::PFW_LOAD;
        end
      end
      pfw_pkg::PFW_LOAD: begin
        // Stream every holding byte to the array's page buffer
        // Bytes flagged keep are left as they are in the array
        c_d.fl_we   = 1'b1;
        c_d.fl_addr = c_q.base | {10'h0, c_q.idx};
        c_d.fl_data = c_q.hold[c_q.idx];
        c_d.fl_keep = (c_q.hold[c_q.idx] == `PFW_HOLD_RST);
        c_d.idx     = c_q.idx + 6'h1;
        if (c_q.idx == `PFW_IDX_LAST) begin
          c_d.tmr_go  = 1'b1;
          c_d.fl_prog = 1'b1;
          c_d.state   = pfw_pkg::PFW_WAIT;
        end
      end
      pfw_pkg::PFW_WAIT: begin
        // Array programs while the timer runs; core stays halted
        if (tmr_done) begin
          c_d.fl_prog = 1'b0;
          c_d.state   = pfw_pkg::PFW_DONE;
        end
      end
      pfw_pkg::PFW_DONE: begin
        // Release the core and reload the erased pattern in one step
        c_d.wr    = 1'b0;
        sts_set[`PFW_IRQ_DONE] = 1'b1;
        c_d.hold  = {`PFW_BLK_BYTES{`PFW_HOLD_RST}};
        c_d.stall = 1'b0;
        c_d.state = pfw_pkg::PFW_IDLE;
      end
      default: begin
        // Unused encodings fall back to idle
        c_d.state = pfw_pkg::PFW_IDLE;
      end
    endcase

    // ------------------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------------------
    // Error flag holds until software writes one to it
    sts_set[`PFW_IRQ_ERR] = err_set;
    c_d.err = (c_q.err && !err_clr) || err_set;
    c_d.sts = w1c(c_q.sts, sts_clr, sts_set);

    // Interrupt follows the unmasked sticky bits
    c_d.irq = |(c_d.sts & c_d.msk);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Holding bytes reset to erased value so unloaded bytes stay as they are
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      c_q       <= '0;
      c_q.state <= pfw_pkg::PFW_IDLE;
      c_q.hold  <= {`PFW_BLK_BYTES{`PFW_HOLD_RST}};
    end else begin
      c_q <= c_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flops
  // --------------------------------------------------------------------------

  assign PRDATA_O    = c_q.prdata;
  assign PREADY_O    = c_q.pready;
  assign PSLVERR_O   = c_q.pslverr;
  assign IRQ_O       = c_q.irq;
  assign CPU_STALL_O = c_q.stall;
  assign FL_WE_O     = c_q.fl_we;
  assign FL_ADDR_O   = c_q.fl_addr;
  assign FL_DATA_O   = c_q.fl_data;
  assign FL_KEEP_O   = c_q.fl_keep;
  assign FL_PROG_O   = c_q.fl_prog;

endmodule

`default_nettype wire

// ===== include/pfw_defines.svh
// Constants for the program flash block writer
// ----------------------------------------------------------------------------
// Overview of operation
// - Flash is programmed only as a whole write block, never a single word or byte.
// - There is exactly one byte-wide holding register per byte of the write block.
// - Table writes only load holding registers, ignore protection and never touch flash.
// - Loading the holding registers leaves the completion flag unchanged.
// - A protected or invalid pointer clears write-start, programs nothing, raises the error.
// - The core is held suspended for the whole long write and resumes when it ends.
// - Seen from the core, the long write completes within one instruction cycle.
// - On completion write-start clears, the done flag sets and an enabled interrupt fires.
// - After programming all holding registers return to all ones; write-enable is kept.
// - The write time is set by an internal programming timer, not by software.
// - Holding registers read FFh after any reset and after each write operation; a start refused for its pointer leaves them loaded.
// - A holding register at FFh leaves its flash byte unmodified.
// ----------------------------------------------------------------------------
`ifndef PFW_DEFINES_SVH
`define PFW_DEFINES_SVH

// Block geometry
`define PFW_BLK_BYTES    64
`define PFW_IDX_W        6
`define PFW_IDX_LAST     6'h3F
`define PFW_HOLD_RST     8'hFF
`define PFW_FLASH_TOP    16'hF000

// Register byte offsets
`define PFW_OFS_CTRL     8'h00
`define PFW_OFS_UNLOCK   8'h04
`define PFW_OFS_PTR      8'h08
`define PFW_OFS_TBLWR    8'h0C
`define PFW_OFS_PROT     8'h10
`define PFW_OFS_IRQSTS   8'h14
`define PFW_OFS_IRQMSK   8'h18
`define PFW_OFS_STAT     8'h1C

// Control field positions
`define PFW_CTRL_WR      0
`define PFW_CTRL_WRITE_ENABLE_BIT    1
`define PFW_CTRL_PMSEL   2
`define PFW_CTRL_ERR     3

// Interrupt status field positions
`define PFW_IRQ_DONE     0
`define PFW_IRQ_ERR      1

// Unlock keys
`define PFW_KEY1         8'h55
`define PFW_KEY2         8'hAA

// Timing
`define PFW_CLK_MHZ      100
`define PFW_PROG_TIME_US 2000
`define PFW_PROG_CYCLES  (`PFW_PROG_TIME_US * `PFW_CLK_MHZ)

`endif

// ===== include/pfw_pkg.sv
// Types for the program flash block writer
`include "pfw_defines.svh"

package pfw_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    PFW_IDLE,
    PFW_CHECK,
    PFW_LOAD,
    PFW_WAIT,
    PFW_DONE
  } pfw_state_t;

  // Whole state of the writer
  typedef struct packed {
    pfw_state_t                               state;
    logic [`PFW_BLK_BYTES-1:0][7:0]           hold;
    logic [7:0]                               latch;
    logic [15:0]                              ptr;
    logic [15:0]                              prot;
    logic [15:0]                              base;
    logic [`PFW_IDX_W-1:0]                    idx;
    logic                                     wr;
    logic                                     write_enable_bit;
    logic                                     pmsel;
    logic                                     err;
    logic                                     key1;
    logic                                     armed;
    logic [1:0]                               sts;
    logic [1:0]                               msk;
    logic                                     irq;
    logic                                     stall;
    logic                                     tmr_go;
    logic                                     fl_we;
    logic [15:0]                              fl_addr;
    logic [7:0]                               fl_data;
    logic                                     fl_keep;
    logic                                     fl_prog;
    logic                                     pready;
    logic                                     pslverr;
    logic [31:0]                              prdata;
  } pfw_core_t;

  // Whole state of the programming timer
  typedef struct packed {
    logic        busy;
    logic [31:0] cnt;
    logic        done;
  } pfw_tmr_t;

endpackage

// ===== logic/pfw_prog_timer.sv
// Programming time counter for the flash block writer
`timescale 1ns/10ps
`default_nettype none

module pfw_prog_timer #(
  parameter int unsigned CYCLES = 200000
) (
  input  wire logic CLK_SYS_I, // System clock
  input  wire logic RST_I,     // Asynchronous reset, active high
  input  wire logic go_i,      // Start pulse
  output logic      busy_o,    // Timer running
  output logic      done_o     // One-cycle pulse at expiry
);

  pfw_pkg::pfw_tmr_t t_q;
  pfw_pkg::pfw_tmr_t t_d;

  // Count up through the write time; software has no say in its length
  always_comb begin
    t_d      = t_q;
    t_d.done = 1'b0;
    if (go_i && !t_q.busy) begin
      t_d.busy = 1'b1;
      t_d.cnt  = 32'h0;
    end else if (t_q.busy) begin
      if (t_q.cnt >= CYCLES - 1) begin
        t_d.busy = 1'b0;
        t_d.done = 1'b1;
      end else begin
        t_d.cnt = t_q.cnt + 32'h1;
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign busy_o = t_q.busy;
  assign done_o = t_q.done;

endmodule

`default_nettype wire

// ===== tb/pfw_writer_assertions.sv
// Assertion checker bound to the flash block writer ports
`timescale 1ns/10ps
`default_nettype none

module pfw_writer_assertions #(
  parameter int unsigned PROG_CYCLES = 200000
) (
  input wire logic        CLK_SYS_I,   // Clock
  input wire logic        RST_I,       // Reset
  input wire logic        PSEL_I,      // Select
  input wire logic        PENABLE_I,   // Enable
  input wire logic        PREADY_O,    // Ready
  input wire logic        PSLVERR_O,   // Error
  input wire logic        CPU_STALL_O, // Core hold
  input wire logic        FL_WE_O,     // Byte load
  input wire logic [15:0] FL_ADDR_O,   // Byte address
  input wire logic [7:0]  FL_DATA_O,   // Byte data
  input wire logic        FL_KEEP_O,   // Keep byte
  input wire logic        FL_PROG_O    // Program window
);
  logic [7:0]  we_run_q;
  logic [31:0] prog_run_q;
  logic [31:0] stall_run_q;

  // ----------------------------------------
  // Run lengths of load burst, program pulse and core stall
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      we_run_q   <= 8'h00;
      prog_run_q <= 32'h0;
      stall_run_q <= 32'h0;
    end else begin
      we_run_q   <= FL_WE_O ? we_run_q + 8'h01 : 8'h00;
      prog_run_q <= FL_PROG_O ? prog_run_q + 32'h1 : 32'h0;
      stall_run_q <= CPU_STALL_O ? stall_run_q + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready not a pulse");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  a_burst_len: assert property ($fell(FL_WE_O) |-> we_run_q == 8'h40)
    else $error("load burst not one block");
  a_addr_step: assert property (FL_WE_O && $past(FL_WE_O) |->
    FL_ADDR_O == $past(FL_ADDR_O) + 16'h0001) else $error("address gap");
  a_keep_ff: assert property (FL_WE_O |-> FL_KEEP_O == (FL_DATA_O == 8'hFF))
    else $error("keep flag wrong");
  a_flash_stall: assert property (FL_WE_O || FL_PROG_O |-> CPU_STALL_O)
    else $error("flash busy without stall");
  a_prog_len: assert property ($fell(FL_PROG_O) |-> prog_run_q >= PROG_CYCLES - 1)
    else $error("program window short");
  a_stall_bound: assert property (CPU_STALL_O |-> stall_run_q < PROG_CYCLES + 68)
    else $error("stall too long");

  c_prog: cover property ($fell(FL_PROG_O));
  c_err: cover property (PSLVERR_O);
  c_short: cover property ($rose(CPU_STALL_O) ##2 !CPU_STALL_O);
endmodule

bind pfw_writer pfw_writer_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CPU_STALL_O(CPU_STALL_O),
  .FL_WE_O(FL_WE_O), .FL_ADDR_O(FL_ADDR_O), .FL_DATA_O(FL_DATA_O),
  .FL_KEEP_O(FL_KEEP_O), .FL_PROG_O(FL_PROG_O));

`default_nettype wire

// ===== tb/pfw_flash_model.sv
// Behavioural flash array side: records the bytes of each load burst
`timescale 1ns/10ps
`default_nettype none

module pfw_flash_model (
  input  wire logic        clk_i,  // Clock
  input  wire logic        clr_i,  // Forget the last burst
  input  wire logic        we_i,   // Byte load
  input  wire logic [15:0] addr_i, // Byte address
  input  wire logic [7:0]  data_i, // Byte data
  input  wire logic        keep_i, // Keep byte
  output logic [63:0][7:0] mem_o,  // Bytes by block offset
  output logic [63:0]      keep_o, // Keep flags by block offset
  output logic [15:0]      cnt_o,  // Bytes loaded since clear
  output logic [15:0]      base_o  // First address of the burst
);
  // Kept bytes are only flagged; each loaded byte is stored as given, FFh included
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      cnt_o <= 16'h0000;
    end else if (we_i) begin
      mem_o[addr_i[5:0]]  <= data_i;
      keep_o[addr_i[5:0]] <= keep_i;
      cnt_o               <= cnt_o + 16'h0001;
      if (cnt_o == 16'h0000) begin
        base_o <= addr_i;
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/pfw_writer_tb.sv
// Self-checking testbench for the flash block writer
`timescale 1ns/10ps
`default_nettype none
`include "pfw_defines.svh"

module pfw_writer_tb;
  logic clk, rst, psel, penable, pwrite, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, PRDATA_O;
  logic PREADY_O, PSLVERR_O, IRQ_O, CPU_STALL_O, FL_WE_O, FL_KEEP_O, FL_PROG_O;
  logic [15:0] FL_ADDR_O, cnt, base;
  logic [7:0] FL_DATA_O;
  logic [63:0][7:0] mem;
  logic [63:0] keep;
  int fails, num_checks, cycles, stall_cyc, prog_cyc;
  localparam int PROG_CYC = 20;

  pfw_writer #(.PROG_CYCLES(PROG_CYC)) pfw_writer_inst (.CLK_SYS_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .IRQ_O(IRQ_O), .CPU_STALL_O(CPU_STALL_O), .FL_WE_O(FL_WE_O), .FL_ADDR_O(FL_ADDR_O),
    .FL_DATA_O(FL_DATA_O), .FL_KEEP_O(FL_KEEP_O), .FL_PROG_O(FL_PROG_O));
  pfw_flash_model pfw_flash_model_inst (.clk_i(clk), .clr_i(clr), .we_i(FL_WE_O),
    .addr_i(FL_ADDR_O), .data_i(FL_DATA_O), .keep_i(FL_KEEP_O), .mem_o(mem),
    .keep_o(keep), .cnt_o(cnt), .base_o(base));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (CPU_STALL_O === 1'b1) stall_cyc++;
    if (FL_PROG_O === 1'b1) prog_cyc++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One transfer; an idle cycle follows so psel never toggles within a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (PREADY_O !== 1'b1);
    r = PRDATA_O;
    e = PSLVERR_O;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask

  // Unlock, start, wait for the stall to end; a one-cycle stall is counted too
  task automatic start_block(input int exp_stall, input int exp_prog);
    clr <= 1'b1;
    stall_cyc = 0;
    prog_cyc = 0;
    @(posedge clk);
    clr <= 1'b0;
    wr(`PFW_OFS_UNLOCK, 32'h55);
    wr(`PFW_OFS_UNLOCK, 32'hAA);
    wr(`PFW_OFS_CTRL, 32'h7);
    do begin
      @(posedge clk);
    end while (CPU_STALL_O !== 1'b0);
    chk("stall", exp_stall, stall_cyc);
    chk("prog", exp_prog, prog_cyc);
  endtask

  task automatic test_reset();
    logic [31:0] r;
    logic e;
    rd("ctrl", `PFW_OFS_CTRL, 32'h0);
    rd("irqsts", `PFW_OFS_IRQSTS, 32'h0);
    rd("stat", `PFW_OFS_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped", 33'h100000000, {e, r});
    $display("test reset done");
  endtask

  task automatic test_block();
    wr(`PFW_OFS_IRQMSK, 32'h3);
    wr(`PFW_OFS_PTR, 32'h1003);
    wr(`PFW_OFS_TBLWR, 32'h12);
    wr(`PFW_OFS_TBLWR, 32'h00);
    wr(`PFW_OFS_TBLWR, 32'hFF);
    rd("latch", `PFW_OFS_TBLWR, 32'hFF);
    rd("ptr", `PFW_OFS_PTR, 32'h1006);
    rd("irqsts", `PFW_OFS_IRQSTS, 32'h0);
    start_block(PROG_CYC + 68, PROG_CYC + 2);
    chk("count", 64, cnt);
    chk("base", 16'h1000, base);
    chk("keep", 64'hFFFFFFFFFFFFFFE7, keep);
    chk("bytes", 16'h1200, {mem[3], mem[4]});
    rd("ctrl", `PFW_OFS_CTRL, 32'h6);
    rd("irqsts", `PFW_OFS_IRQSTS, 32'h1);
    chk("irq", 1, IRQ_O);
    wr(`PFW_OFS_TBLWR, 32'h77);
    rd("irqsts", `PFW_OFS_IRQSTS, 32'h1);
    wr(`PFW_OFS_IRQSTS, 32'h1);
    chk("irq", 0, IRQ_O);
    start_block(PROG_CYC + 68, PROG_CYC + 2);
    chk("keep", 64'hFFFFFFFFFFFFFFBF, keep);
    chk("byte", 8'h77, mem[6]);
    $display("test block done");
  endtask

  task automatic test_error();
    wr(`PFW_OFS_IRQSTS, 32'h3);
    wr(`PFW_OFS_IRQMSK, 32'h0);
    wr(`PFW_OFS_PROT, 32'h2000);
    wr(`PFW_OFS_PTR, 32'h1000);
    rd("prot", `PFW_OFS_PROT, 32'h2000);
    start_block(1, 0);
    chk("count", 0, cnt);
    rd("ctrl", `PFW_OFS_CTRL, 32'hE);
    rd("irqsts", `PFW_OFS_IRQSTS, 32'h2);
    chk("irq", 0, IRQ_O);
    wr(`PFW_OFS_IRQMSK, 32'h2);
    chk("irq", 1, IRQ_O);
    rd("ctrl", `PFW_OFS_CTRL, 32'hE);
    wr(`PFW_OFS_CTRL, 32'h8);
    rd("ctrl", `PFW_OFS_CTRL, 32'h0);
    wr(`PFW_OFS_PROT, 32'h0);
    wr(`PFW_OFS_PTR, {16'h0, `PFW_FLASH_TOP});
    start_block(1, 0);
    chk("count", 0, cnt);
    rd("ctrl", `PFW_OFS_CTRL, 32'hE);
    $display("test error done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; clr = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_block();
    test_error();
    end_of_test();
  end
endmodule

`default_nettype wire
